/* hbfp_chk.sv */
// Purpose: Assertions on the half-bridge fault protection ports
// Assumes: Bench clears flags only well after a shutdown
// Notes: Bridge 0 stands for all bridges in the gate checks other than p_cross and p_glob_off
`timescale 1ns/10ps
module hbfp_chk
    import hbfp_pkg::*;
#(
    parameter int NB = NUM_BRIDGES,
    parameter int OC_CYC = OC_FILTER_CYC
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [NB-1:0] hs_oc_det,
    input wire logic [NB-1:0] hs_ol_det,
    input wire logic temp_warn_det,
    input wire logic temp_sd_det,
    input wire logic supply_uv_det,
    input wire logic supply_ov_det,
    input wire logic [NB-1:0] hs_gate,
    input wire logic [NB-1:0] ls_gate,
    input wire logic fault_indicator_low
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic [15:0] oc_cnt_q, oc_cnt_d;
    logic ol_only;
    logic any_off;
    ////////////////////////////////////////////////////////////////////////////
    // Cycles of overcurrent seen on a conducting high side
    always_comb begin
        oc_cnt_d = (hs_oc_det[0] && hs_gate[0]) ? oc_cnt_q + 16'h1 : 16'h0;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            oc_cnt_q <= 16'h0;
        end else begin
            oc_cnt_q <= oc_cnt_d;
        end
    end
    // Open load with no overcurrent or thermal shutdown around it
    assign ol_only = hs_ol_det[0] & hs_gate[0] & ~hs_oc_det[0] & ~temp_sd_det;
    assign any_off = temp_sd_det | supply_uv_det | supply_ov_det;
    ////////////////////////////////////////////////////////////////////////////
    property p_cross; (hs_gate & ls_gate) == '0; endproperty
    a_cross: assert property (p_cross) else $error("both gates on");
    property p_dead; $rose(ls_gate[0]) |-> !$past(hs_gate[0]) && !$past(hs_gate[0], 2); endproperty
    a_dead: assert property (p_dead) else $error("no dead time");
    property p_glob_off; any_off [*4] |-> hs_gate == '0 && ls_gate == '0; endproperty
    a_glob_off: assert property (p_glob_off) else $error("gates on in fault");
    property p_fault; $rose(temp_warn_det | any_off) |-> ##[1:5] !fault_indicator_low; endproperty
    a_fault: assert property (p_fault) else $error("indicator not low");
    property p_filt; $rose(hs_oc_det[0]) && hs_gate[0] |=> hs_gate[0] [*4]; endproperty
    a_filt: assert property (p_filt) else $error("no filter time");
    property p_oc_off; oc_cnt_q <= 16'(OC_CYC + 4); endproperty
    a_oc_off: assert property (p_oc_off) else $error("no oc shutdown");
    property p_oc_hold; $fell(hs_gate[0]) && hs_oc_det[0] |=> !hs_gate[0] [*6]; endproperty
    a_oc_hold: assert property (p_oc_hold) else $error("oc latch lost");
    property p_ol; (ol_only && !supply_uv_det && !supply_ov_det) [*4] |-> hs_gate[0]; endproperty
    a_ol: assert property (p_ol) else $error("open load cut output");
    c_oc: cover property ($fell(hs_gate[0]) && hs_oc_det[0]);
    c_ol: cover property (ol_only [*4]);
    c_sw: cover property ($rose(ls_gate[0]));
endmodule
bind hbfp_top hbfp_chk #(.NB(NB), .OC_CYC(OC_CYC)) u_hbfp_chk (.hclk(hclk),
    .hresetn(hresetn), .hs_oc_det(hs_oc_det), .hs_ol_det(hs_ol_det),
    .temp_warn_det(temp_warn_det), .temp_sd_det(temp_sd_det), .supply_uv_det(supply_uv_det),
    .supply_ov_det(supply_ov_det), .hs_gate(hs_gate), .ls_gate(ls_gate),
    .fault_indicator_low(fault_indicator_low));

/* hbfp_host.sv */
// Purpose: Host model issuing single word transfers
// Assumes: One slave, its hreadyout is hready
// Notes: Each transfer starts one edge after the call
`timescale 1ns/10ps
module hbfp_host (
    input wire logic hclk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    // Idle bus at time zero
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end
    // Address phase, then data phase; flag clears go through here
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge hclk); while (!hready);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (!hready);
        rd = hrdata;
    endtask
endmodule

/* hbfp_pkg.sv */
// Purpose: Constants for the half-bridge fault protection block
// Assumes: 20 MHz hclk, AHB-Lite register access
// Notes: Operation
package hbfp_pkg;
    localparam int NUM_BRIDGES = 12;
    localparam int CLK_HZ = 20_000_000;
    // Overcurrent shutdown filter, in ns
    localparam int OC_FILTER_NS = 20_000;
    localparam int OC_FILTER_CYC = (OC_FILTER_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    // Open load filter, in ns
    localparam int OL_FILTER_NS = 200_000;
    localparam int OL_FILTER_CYC = (OL_FILTER_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    // Dead time, in ns
    localparam int DEAD_NS = 1_000;
    localparam int DEAD_CYC = (DEAD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int CNT_W = 16;
    // Register byte addresses
    localparam logic [7:0] ADDR_GSTAT = 8'h00;
    localparam logic [7:0] ADDR_HS_OC = 8'h04;
    localparam logic [7:0] ADDR_LS_OC = 8'h08;
    localparam logic [7:0] ADDR_HS_OL = 8'h0C;
    localparam logic [7:0] ADDR_LS_OL = 8'h10;
    localparam logic [7:0] ADDR_HS_ACT = 8'h14;
    localparam logic [7:0] ADDR_LS_ACT = 8'h18;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h1C;
    localparam logic [7:0] ADDR_IRQ_CLR = 8'h20;
    // Global status bit positions
    localparam int GS_TPW_BIT = 1;
    localparam int GS_TSD_BIT = 2;
    localparam int GS_OV_BIT = 4;
    localparam int GS_UV_BIT = 5;
    localparam int GS_LE_BIT = 6;
    localparam int GS_W = 7;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

/* hbfp_top.sv */
// Purpose: Fault supervision, latching and dead time for half bridges
// Assumes: Comparator inputs are asynchronous levels from analog
// Notes: Status flags clear by writing ones to the status offsets
//
// Added by the designer: the register addresses and the AHB-Lite slave port.
`timescale 1ns/10ps
module hbfp_top
    import hbfp_pkg::*;
#(
    parameter int NB = NUM_BRIDGES,
    parameter int OC_CYC = OC_FILTER_CYC,
    parameter int OL_CYC = OL_FILTER_CYC,
    parameter int DT_CYC = DEAD_CYC
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [NB-1:0] hs_oc_det,
    input wire logic [NB-1:0] ls_oc_det,
    input wire logic [NB-1:0] hs_ol_det,
    input wire logic [NB-1:0] ls_ol_det,
    input wire logic temp_warn_det,
    input wire logic temp_sd_det,
    input wire logic supply_uv_det,
    input wire logic supply_ov_det,
    output logic [NB-1:0] hs_gate,
    output logic [NB-1:0] ls_gate,
    output logic fault_indicator_low,
    output logic irq
);
    localparam int NI = 4 * NB + 4;

    ////////////////////////////////////////////////////////////////////////////
    // Two-stage synchronisers for all analog detector levels
    logic [NI-1:0] meta_q, sync_q;
    logic [NI-1:0] raw_in;
    assign raw_in = {hs_oc_det, ls_oc_det, hs_ol_det, ls_ol_det,
                     temp_warn_det, temp_sd_det, supply_uv_det, supply_ov_det};
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= raw_in;
            sync_q <= meta_q;
        end
    end
    logic [NB-1:0] s_hs_oc, s_ls_oc, s_hs_ol, s_ls_ol;
    logic s_tw, s_tsd, s_uv, s_ov;
    assign {s_hs_oc, s_ls_oc, s_hs_ol, s_ls_ol, s_tw, s_tsd, s_uv, s_ov} = sync_q;

    ////////////////////////////////////////////////////////////////////////////
    // Bus address phase capture
    logic wr_pend_q, wr_pend_d, rd_sel;
    logic [7:0] waddr_q, waddr_d;
    logic [31:0] hrdata_q, hrdata_d;
    logic acc;
    assign acc = hsel && hready && (htrans == HTRANS_NONSEQ);
    assign rd_sel = acc && !hwrite;
    logic wr_now;
    assign wr_now = wr_pend_q;

    // Control and status registers
    logic [NB-1:0] hs_act_q, hs_act_d, ls_act_q, ls_act_d;
    logic [NB-1:0] hs_ocf_q, hs_ocf_d, ls_ocf_q, ls_ocf_d;
    logic [NB-1:0] hs_olf_q, hs_olf_d, ls_olf_q, ls_olf_d;
    logic [GS_W-1:0] gs_q, gs_d;
    logic [GS_W-1:0] ien_q, ien_d, ist_q, ist_d;
    logic [NB-1:0] hs_oc_exp, ls_oc_exp, hs_ol_exp, ls_ol_exp;
    logic [GS_W-1:0] gs_set;

    // Clear masks for write-one-to-clear flags
    function automatic logic [NB-1:0] clr_of(input logic [7:0] a, input logic [7:0] tgt,
                                             input logic en, input logic [31:0] d);
        clr_of = (en && a == tgt) ? d[NB-1:0] : '0;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Per-switch filter timers; only activated, running switches count
    logic [CNT_W-1:0] hs_oct_q [NB], hs_oct_d [NB], ls_oct_q [NB], ls_oct_d [NB];
    logic [CNT_W-1:0] hs_olt_q [NB], hs_olt_d [NB], ls_olt_q [NB], ls_olt_d [NB];
    always_comb begin
        for (int i = 0; i < NB; i++) begin
            hs_oct_d[i] = '0;
            ls_oct_d[i] = '0;
            hs_olt_d[i] = '0;
            ls_olt_d[i] = '0;
            hs_oc_exp[i] = 1'b0;
            ls_oc_exp[i] = 1'b0;
            hs_ol_exp[i] = 1'b0;
            ls_ol_exp[i] = 1'b0;
            // High side short to ground, low side short to supply
            if (hs_gate[i] && s_hs_oc[i]) begin
                hs_oct_d[i] = hs_oct_q[i] + 1'b1;
                hs_oc_exp[i] = (hs_oct_q[i] >= CNT_W'(OC_CYC - 1));
            end
            if (ls_gate[i] && s_ls_oc[i]) begin
                ls_oct_d[i] = ls_oct_q[i] + 1'b1;
                ls_oc_exp[i] = (ls_oct_q[i] >= CNT_W'(OC_CYC - 1));
            end
            if (hs_gate[i] && s_hs_ol[i]) begin
                hs_olt_d[i] = hs_olt_q[i] + 1'b1;
                hs_ol_exp[i] = (hs_olt_q[i] >= CNT_W'(OL_CYC - 1));
            end
            if (ls_gate[i] && s_ls_ol[i]) begin
                ls_olt_d[i] = ls_olt_q[i] + 1'b1;
                ls_ol_exp[i] = (ls_olt_q[i] >= CNT_W'(OL_CYC - 1));
            end
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < NB; i++) begin
                hs_oct_q[i] <= '0;
                ls_oct_q[i] <= '0;
                hs_olt_q[i] <= '0;
                ls_olt_q[i] <= '0;
            end
        end else begin
            hs_oct_q <= hs_oct_d;
            ls_oct_q <= ls_oct_d;
            hs_olt_q <= hs_olt_d;
            ls_olt_q <= ls_olt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register file and flag latching; set wins over clear
    always_comb begin
        wr_pend_d = acc && hwrite;
        waddr_d = acc ? haddr[7:0] : waddr_q;
        hs_act_d = hs_act_q;
        ls_act_d = ls_act_q;
        ien_d = ien_q;
        if (wr_now && waddr_q == ADDR_HS_ACT) begin
            hs_act_d = hwdata[NB-1:0];
        end
        if (wr_now && waddr_q == ADDR_LS_ACT) begin
            ls_act_d = hwdata[NB-1:0];
        end
        if (wr_now && waddr_q == ADDR_IRQ_EN) begin
            ien_d = hwdata[GS_W-1:0];
        end
        hs_ocf_d = (hs_ocf_q & ~clr_of(waddr_q, ADDR_HS_OC, wr_now, hwdata)) | hs_oc_exp;
        ls_ocf_d = (ls_ocf_q & ~clr_of(waddr_q, ADDR_LS_OC, wr_now, hwdata)) | ls_oc_exp;
        hs_olf_d = (hs_olf_q & ~clr_of(waddr_q, ADDR_HS_OL, wr_now, hwdata)) | hs_ol_exp;
        ls_olf_d = (ls_olf_q & ~clr_of(waddr_q, ADDR_LS_OL, wr_now, hwdata)) | ls_ol_exp;
        gs_set = '0;
        gs_set[GS_TPW_BIT] = s_tw;
        gs_set[GS_TSD_BIT] = s_tsd;
        gs_set[GS_OV_BIT] = s_ov;
        gs_set[GS_UV_BIT] = s_uv;
        gs_set[GS_LE_BIT] = |{hs_oc_exp, ls_oc_exp, hs_ol_exp, ls_ol_exp};
        gs_d = gs_q;
        if (wr_now && waddr_q == ADDR_GSTAT) begin
            gs_d = gs_q & ~hwdata[GS_W-1:0];
        end
        gs_d = gs_d | gs_set;
        // Interrupt status records newly set global events
        ist_d = ist_q;
        if (wr_now && waddr_q == ADDR_IRQ_CLR) begin
            ist_d = ist_q & ~hwdata[GS_W-1:0];
        end
        ist_d = ist_d | (gs_set & ~gs_q);
        hrdata_d = hrdata_q;
        if (rd_sel) begin
            case (haddr[7:0])
                ADDR_GSTAT: hrdata_d = 32'(gs_q);
                ADDR_HS_OC: hrdata_d = 32'(hs_ocf_q);
                ADDR_LS_OC: hrdata_d = 32'(ls_ocf_q);
                ADDR_HS_OL: hrdata_d = 32'(hs_olf_q);
                ADDR_LS_OL: hrdata_d = 32'(ls_olf_q);
                ADDR_HS_ACT: hrdata_d = 32'(hs_act_q);
                ADDR_LS_ACT: hrdata_d = 32'(ls_act_q);
                ADDR_IRQ_EN: hrdata_d = 32'(ien_q);
                default: hrdata_d = 32'h0000_0000;
            endcase
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            waddr_q <= 8'h00;
            hrdata_q <= 32'h0000_0000;
            hs_act_q <= '0;
            ls_act_q <= '0;
            hs_ocf_q <= '0;
            ls_ocf_q <= '0;
            hs_olf_q <= '0;
            ls_olf_q <= '0;
            gs_q <= '0;
            ien_q <= '0;
            ist_q <= '0;
        end else begin
            wr_pend_q <= wr_pend_d;
            waddr_q <= waddr_d;
            hrdata_q <= hrdata_d;
            hs_act_q <= hs_act_d;
            ls_act_q <= ls_act_d;
            hs_ocf_q <= hs_ocf_d;
            ls_ocf_q <= ls_ocf_d;
            hs_olf_q <= hs_olf_d;
            ls_olf_q <= ls_olf_d;
            gs_q <= gs_d;
            ien_q <= ien_d;
            ist_q <= ist_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Gate drive with fault blocking and dead time
    logic [NB-1:0] hs_req, ls_req, hs_gate_d, ls_gate_d;
    logic [CNT_W-1:0] dt_q [NB], dt_d [NB];
    logic glob_off;
    // Thermal shutdown latched by flag; supply faults follow live level
    assign glob_off = gs_q[GS_TSD_BIT] || s_tsd || s_uv || s_ov;
    always_comb begin
        for (int i = 0; i < NB; i++) begin
            hs_req[i] = hs_act_q[i] && !hs_ocf_q[i] && !hs_oc_exp[i] && !glob_off;
            ls_req[i] = ls_act_q[i] && !ls_ocf_q[i] && !ls_oc_exp[i] && !glob_off;
            if (hs_req[i] && ls_req[i]) begin
                ls_req[i] = 1'b0;
            end
            hs_gate_d[i] = hs_req[i] && hs_gate[i];
            ls_gate_d[i] = ls_req[i] && ls_gate[i];
            dt_d[i] = (dt_q[i] != '0) ? dt_q[i] - 1'b1 : '0;
            if (hs_gate[i] && !hs_req[i] || ls_gate[i] && !ls_req[i]) begin
                dt_d[i] = CNT_W'(DT_CYC);
            end else if (dt_q[i] == '0 && !hs_gate[i] && !ls_gate[i]) begin
                hs_gate_d[i] = hs_req[i];
                ls_gate_d[i] = ls_req[i] && !hs_req[i];
            end
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hs_gate <= '0;
            ls_gate <= '0;
            fault_indicator_low <= 1'b1;
            irq <= 1'b0;
            for (int i = 0; i < NB; i++) begin
                dt_q[i] <= '0;
            end
        end else begin
            hs_gate <= hs_gate_d;
            ls_gate <= ls_gate_d;
            fault_indicator_low <= ~(|gs_d);
            irq <= |(ist_d & ien_d);
            dt_q <= dt_d;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;
endmodule

/* tb_top.sv */
// Purpose: Directed test of fault latching, gates and interrupt
// Assumes: Short filter and dead time parameters
// Notes: Gate vector compared as {hs_gate, ls_gate}
`timescale 1ns/10ps
module tb_top
    import hbfp_pkg::*;
;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, fault_indicator_low;
    logic temp_warn_det, temp_sd_det, supply_uv_det, supply_ov_det;
    logic [31:0] haddr, hwdata, hrdata, rv;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [11:0] hs_oc_det, ls_oc_det, hs_ol_det, ls_ol_det, hs_gate, ls_gate;
    int error_cnt = 0;
    int comparisons = 0;
    int cyc = 0;
    int bitn[4] = '{1, 2, 4, 5};
    hbfp_host u_hbfp_host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
    hbfp_top #(.OC_CYC(4), .OL_CYC(4), .DT_CYC(4)) u_hbfp_top (.hclk(hclk),
        .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .hs_oc_det(hs_oc_det), .ls_oc_det(ls_oc_det),
        .hs_ol_det(hs_ol_det), .ls_ol_det(ls_ol_det), .temp_warn_det(temp_warn_det),
        .temp_sd_det(temp_sd_det), .supply_uv_det(supply_uv_det),
        .supply_ov_det(supply_ov_det), .hs_gate(hs_gate), .ls_gate(ls_gate),
        .fault_indicator_low(fault_indicator_low), .irq(irq));
    ////////////////////////////////////////////////////////////////////////////
    // Clock and hang guard
    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            summarize();
        end
    end
    // Compare, bus wrappers and wait
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_hbfp_host.xfer(1'b1, a, d, rv);
    endtask
    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
        u_hbfp_host.xfer(1'b0, a, 32'h0, rv);
        chk(nm, rv, e);
    endtask
    task automatic gates(input logic [31:0] e);
        repeat (12) @(posedge hclk);
        chk("gates", {8'h00, hs_gate, ls_gate}, e);
    endtask
    task automatic summarize();
        if (error_cnt == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        hresetn = 1'b0;
        {temp_warn_det, temp_sd_det, supply_uv_det, supply_ov_det} = 4'h0;
        {hs_oc_det, ls_oc_det, hs_ol_det, ls_ol_det} = 48'h0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        rd("gstat", ADDR_GSTAT, 32'h0);
        rd("unmapped", 8'h40, 32'h0);
        chk("resp", {30'h0, hreadyout, hresp}, 32'h2);
        wr(ADDR_HS_ACT, 32'h1);
        wr(ADDR_LS_ACT, 32'h2);
        gates(32'h0001002);
        wr(ADDR_HS_ACT, 32'h0);
        wr(ADDR_LS_ACT, 32'h3);
        gates(32'h0000003);
        wr(ADDR_LS_ACT, 32'h2);
        wr(ADDR_HS_ACT, 32'h1);
        gates(32'h0001002);
        @(posedge hclk);
        hs_oc_det[0] <= 1'b1;
        ls_oc_det[5] <= 1'b1;
        gates(32'h0000002);
        rd("hs oc", ADDR_HS_OC, 32'h1);
        rd("ls oc", ADDR_LS_OC, 32'h0);
        rd("gstat le", ADDR_GSTAT, 32'h40);
        rd("hs act", ADDR_HS_ACT, 32'h1);
        chk("fault", {31'h0, fault_indicator_low}, 32'h0);
        wr(ADDR_HS_OC, 32'h1);
        gates(32'h0000002);
        rd("hs oc again", ADDR_HS_OC, 32'h1);
        @(posedge hclk);
        hs_oc_det[0] <= 1'b0;
        ls_oc_det[5] <= 1'b0;
        wr(ADDR_HS_OC, 32'h1);
        wr(ADDR_GSTAT, 32'h40);
        gates(32'h0001002);
        @(posedge hclk);
        hs_ol_det[0] <= 1'b1;
        gates(32'h0001002);
        rd("hs ol", ADDR_HS_OL, 32'h1);
        rd("gstat ol", ADDR_GSTAT, 32'h40);
        @(posedge hclk);
        hs_ol_det[0] <= 1'b0;
        wr(ADDR_HS_OL, 32'h1);
        wr(ADDR_GSTAT, 32'h40);
        // Warning, shutdown, overvoltage, undervoltage in turn
        for (int i = 0; i < 4; i++) begin
            @(posedge hclk);
            {supply_uv_det, supply_ov_det, temp_sd_det, temp_warn_det} <= 4'h1 << i;
            gates((i == 0) ? 32'h0001002 : 32'h0);
            rd("gstat ev", ADDR_GSTAT, 32'h1 << bitn[i]);
            chk("fault ev", {31'h0, fault_indicator_low}, 32'h0);
            @(posedge hclk);
            {supply_uv_det, supply_ov_det, temp_sd_det, temp_warn_det} <= 4'h0;
            gates((i == 1) ? 32'h0 : 32'h0001002);
            wr(ADDR_GSTAT, 32'hFF);
            gates(32'h0001002);
            rd("gstat clr", ADDR_GSTAT, 32'h0);
        end
        // Interrupt raised, cleared, then masked
        wr(ADDR_IRQ_EN, 32'h2);
        @(posedge hclk);
        temp_warn_det <= 1'b1;
        repeat (8) @(posedge hclk);
        chk("irq on", {31'h0, irq}, 32'h1);
        temp_warn_det <= 1'b0;
        // Let the synchronised level fall so the clear really takes
        repeat (4) @(posedge hclk);
        wr(ADDR_GSTAT, 32'h2);
        wr(ADDR_IRQ_CLR, 32'h2);
        wr(ADDR_IRQ_EN, 32'h0);
        chk("irq clr", {31'h0, irq}, 32'h0);
        temp_warn_det <= 1'b1;
        repeat (8) @(posedge hclk);
        chk("irq mask", {31'h0, irq}, 32'h0);
        summarize();
    end
endmodule
